// >>> st_ctrl_pkg.sv
/*
 * Shared constants and carrier types for the S/T transceiver control master:
 * register map, reset values, field positions, preset frame contents.
 * Assumes a 32-bit AHB-Lite register bus and a single 200 MHz clock.
 */
package st_ctrl_pkg;

    // Register byte addresses
    localparam logic [7:0] MODE_ADDR     = 8'h00;
    localparam logic [7:0] CTRL_ADDR     = 8'h04;
    localparam logic [7:0] TXDATA_ADDR   = 8'h08;
    localparam logic [7:0] RXDATA_ADDR   = 8'h0c;
    localparam logic [7:0] STATUS_ADDR   = 8'h10;
    localparam logic [7:0] PA_DIR_ADDR   = 8'h14;
    localparam logic [7:0] PA_FUNC_ADDR  = 8'h18;
    localparam logic [7:0] PA_DATA_ADDR  = 8'h1c;

    // Reset values
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [15:0] PA_DIR_RST   = 16'h0000;
    localparam logic [15:0] PA_FUNC_RST  = 16'h0000;
    localparam logic [15:0] PA_DATA_RST  = 16'h0000;
    localparam logic [15:0] TXDATA_RST   = 16'h0000;

    // Mode register fields
    localparam int MODE_INV_BIT  = 5;     // Clock invert
    localparam int MODE_DIV_LSB  = 0;     // Half period minus one, 4 bits
    localparam logic [7:0] MODE_TYPICAL = 8'h2f;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_TWO_BIT   = 1;
    localparam int CTRL_PRE_LSB   = 4;    // Preset select, 3 bits

    // Status register fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_DONE_BIT   = 1;
    localparam int ST_REFUSE_BIT = 2;
    localparam int ST_DELTA_BIT  = 3;
    localparam int ST_IRQ_BIT    = 4;
    localparam int ST_XRST_BIT   = 5;
    localparam int ST_NT_BIT     = 6;

    // Port A pin positions
    localparam int PA_RXD_PIN  = 0;
    localparam int PA_TXD_PIN  = 1;
    localparam int PA_CTS_OUT  = 2;
    localparam int PA_TCLK_PIN = 3;
    localparam int PA_CTS_PIN  = 4;
    localparam int PA_CD_OUT   = 5;
    localparam int PA_CD_PIN   = 6;
    localparam int PA_SEL_PIN  = 7;
    localparam int PA_XRST_PIN = 8;
    localparam logic [15:0] PA_DIR_TYPICAL   = 16'h01a4;
    localparam logic [15:0] PA_FUNC_POLLED   = 16'h000b;
    localparam logic [15:0] PA_FUNC_MODEM    = 16'h005b;
    localparam logic        SEL_ACTIVE       = 1'b1;

    // Transceiver frame contents
    localparam logic [7:0] BYTE_WR_HDR    = 8'h80;
    localparam logic [2:0] CFG_BYTE_REG   = 3'h7;
    localparam logic [7:0] CFG_NT_VALUE   = 8'h0c;
    localparam logic [7:0] CFG_TE_VALUE   = 8'h04;
    localparam logic [3:0] LOOP_NIB_REG   = 4'h2;
    localparam logic [3:0] MASK_NIB_REG   = 4'h4;
    localparam logic [3:0] BCH_NIB_REG    = 4'h5;
    localparam logic [3:0] BCH_BOTH_VALUE = 4'hc;
    localparam logic [3:0] LOOP_ACT_VALUE = 4'h8;
    localparam logic [3:0] LOOP_DEACT_VAL = 4'h4;

    // Preset codes in the control register
    localparam logic [2:0] PRE_NONE    = 3'd0;
    localparam logic [2:0] PRE_NT_CFG  = 3'd1;
    localparam logic [2:0] PRE_TE_CFG  = 3'd2;
    localparam logic [2:0] PRE_TE_BCH  = 3'd3;
    localparam logic [2:0] PRE_LOOP_ON = 3'd4;
    localparam logic [2:0] PRE_LOOP_OFF= 3'd5;
    localparam logic [2:0] PRE_MASK    = 3'd6;

    localparam logic [4:0] BITS_ONE = 5'd8;
    localparam logic [4:0] BITS_TWO = 5'd16;

    // Serial link pins driven by the master
    typedef struct packed {
        logic sclk;
        logic mosi;
    } link_out_t;

    // Port A pin group
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } port_drive_t;

endpackage

// >>> st_ctrl_master.sv
/*
 * Control master for an external S/T interface transceiver: serial control
 * link shifter, port A pin multiplexing, transceiver reset and irq sensing.
 * Assumes an AHB-Lite master with word accesses; pins are asynchronous.
 */
`timescale 1ns/100ps

// Summary of operation
// - Device masters link, makes shift clock.
// - Mode 2F: idle high, fall out, rise in.
// - Mode 2F divides system clock by 32.
// - Transaction starts when start bit set or a preset code chosen.
// - Select asserted before, negated after each transaction.
// - Byte register write is two bytes.
// - Nibble write is one address/data byte.
// - Byte read: two bytes, data in second.
// - Nibble read: one byte, data follows after.
// - Transceiver irq feeds level one input.
// - Software pulses transceiver reset through port pin.
// - Network termination: byte reg seven gets 0C.
// - Terminal: 04 to reg seven, C nibble five.
// - Loop on writes 8, off writes 4.
// - Direction 01A4 makes pins 2,5,7,8 outputs.
// - Function 000B dedicates receive, transmit, clock pins.
// - Function 005B also dedicates modem inputs.
// - Polled handshake levels read from port data.
// - Dedicated handshake pins flag any change.
module st_ctrl_master (
    // Clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // Serial control link
    output st_ctrl_pkg::link_out_t         link_out,
    input  wire logic                      link_miso,
    // Port A pins
    output st_ctrl_pkg::port_drive_t       port_a,
    input  wire logic [15:0]               port_a_in,
    // Transceiver interrupt, active low, and its level one request
    input  wire logic                      xcvr_irq_n,
    output logic                           level_one_irq_input,
    // Second serial channel side of port A
    output logic                           chan2_rx_line,
    input  wire logic                      chan2_tx_line,
    input  wire logic                      chan2_tx_clock,
    output logic                           chan2_clear_to_send,
    output logic                           chan2_carrier_detect,
    output logic                           chan2_change_event
);
    import st_ctrl_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_LEAD, S_TRAIL} shift_state_t;

    // Builds the first byte of a byte register access
    function automatic logic [7:0] byte_hdr(input logic [2:0] addr);
        byte_hdr = BYTE_WR_HDR | {5'h00, addr};
    endfunction

    // Builds a nibble register write byte
    function automatic logic [7:0] nib_frame(input logic [3:0] addr, input logic [3:0] data);
        nib_frame = {addr, data};
    endfunction

    logic [7:0]   mode_r;
    logic [15:0]  txdata_r;
    logic [15:0]  rxdata_r;
    logic [15:0]  pa_dir_r;
    logic [15:0]  pa_func_r;
    logic [15:0]  pa_data_r;
    logic         done_r;
    logic         refuse_r;
    logic         delta_r;
    logic         nt_mode_r;
    logic         ap_valid_r;
    logic         ap_write_r;
    logic [7:0]   ap_addr_r;
    logic         rd_wait_r;
    logic [31:0]  hrdata_r;
    shift_state_t state_r;
    logic [15:0]  shift_r;
    logic [4:0]   bit_cnt_r;
    logic [4:0]   bit_total_r;
    logic [3:0]   div_cnt_r;
    logic         sclk_r;
    logic         mosi_r;
    logic [15:0]  pa_meta_r;
    logic [15:0]  pa_sync_r;
    logic [1:0]   meta_r;
    logic [1:0]   sync_r;
    logic [1:0]   hs_last_r;

    // Bus decode
    logic        addr_phase;
    logic        wr_now;
    logic        ctrl_wr;
    logic        status_wr;
    logic [2:0]  preset;
    logic        go_req;
    logic        sel_on;
    logic        off_blocked;
    logic        go;
    logic [15:0] frame;
    logic        two;
    logic        inv;
    logic [3:0]  half;
    logic        tick;
    logic        last_bit;
    logic        finish;
    logic        miso_s;
    logic        irq_s;
    logic        ded_cts;
    logic        ded_cd;
    logic        hs_change;
    logic [15:0] pa_read;
    logic [31:0] rd_val;

    assign addr_phase = hsel & htrans[1] & hready;
    assign wr_now     = ap_valid_r & ap_write_r;
    assign ctrl_wr    = wr_now & (ap_addr_r == CTRL_ADDR);
    assign status_wr  = wr_now & (ap_addr_r == STATUS_ADDR);
    assign preset     = hwdata[CTRL_PRE_LSB +: 3];
    assign go_req     = ctrl_wr & (hwdata[CTRL_START_BIT] | (preset != PRE_NONE));
    assign sel_on     = pa_dir_r[PA_SEL_PIN] & (pa_data_r[PA_SEL_PIN] == SEL_ACTIVE);
    assign off_blocked = (preset == PRE_LOOP_OFF) & ~nt_mode_r;
    assign go         = go_req & (state_r == S_IDLE) & sel_on & ~off_blocked;

    // Transmit frame selection, first byte in the upper half
    always_comb begin
        frame = txdata_r;
        two   = hwdata[CTRL_TWO_BIT];
        case (preset)
            PRE_NT_CFG: begin
                frame = {byte_hdr(CFG_BYTE_REG), CFG_NT_VALUE};
                two   = 1'b1;
            end
            PRE_TE_CFG: begin
                frame = {byte_hdr(CFG_BYTE_REG), CFG_TE_VALUE};
                two   = 1'b1;
            end
            PRE_TE_BCH: begin
                frame = {nib_frame(BCH_NIB_REG, BCH_BOTH_VALUE), 8'h00};
                two   = 1'b0;
            end
            PRE_LOOP_ON: begin
                frame = {nib_frame(LOOP_NIB_REG, LOOP_ACT_VALUE), 8'h00};
                two   = 1'b0;
            end
            PRE_LOOP_OFF: begin
                frame = {nib_frame(LOOP_NIB_REG, LOOP_DEACT_VAL), 8'h00};
                two   = 1'b0;
            end
            PRE_MASK: begin
                frame = {nib_frame(MASK_NIB_REG, txdata_r[3:0]), 8'h00};
                two   = 1'b0;
            end
            default: ;
        endcase
    end

    // Address phase capture; reads take one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r  <= 8'h00;
            rd_wait_r  <= 1'b0;
        end else begin
            if (hreadyout) begin
                ap_valid_r <= addr_phase;
                ap_write_r <= hwrite;
                ap_addr_r  <= haddr[7:0];
                rd_wait_r  <= addr_phase & ~hwrite;
            end else begin
                rd_wait_r  <= 1'b0;
            end
        end
    end

    // Port A read view: outputs show the latch, inputs the pin
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pa_read[i] = pa_dir_r[i] ? pa_data_r[i] : pa_sync_r[i];
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (ap_addr_r == MODE_ADDR) begin
            rd_val = {24'h000000, mode_r};
        end else if (ap_addr_r == TXDATA_ADDR) begin
            rd_val = {16'h0000, txdata_r};
        end else if (ap_addr_r == RXDATA_ADDR) begin
            rd_val = {16'h0000, rxdata_r};
        end else if (ap_addr_r == STATUS_ADDR) begin
            rd_val[ST_BUSY_BIT]   = (state_r != S_IDLE);
            rd_val[ST_DONE_BIT]   = done_r;
            rd_val[ST_REFUSE_BIT] = refuse_r;
            rd_val[ST_DELTA_BIT]  = delta_r;
            rd_val[ST_IRQ_BIT]    = irq_s;
            rd_val[ST_XRST_BIT]   = pa_dir_r[PA_XRST_PIN] & ~pa_data_r[PA_XRST_PIN];
            rd_val[ST_NT_BIT]     = nt_mode_r;
        end else if (ap_addr_r == PA_DIR_ADDR) begin
            rd_val = {16'h0000, pa_dir_r};
        end else if (ap_addr_r == PA_FUNC_ADDR) begin
            rd_val = {16'h0000, pa_func_r};
        end else if (ap_addr_r == PA_DATA_ADDR) begin
            rd_val = {16'h0000, pa_read};
        end
    end

    // Read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_wait_r) begin
            hrdata_r <= rd_val;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = ~rd_wait_r;
    assign hresp     = 1'b0;

    // Software-written configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r    <= MODE_RST;
            txdata_r  <= TXDATA_RST;
            pa_dir_r  <= PA_DIR_RST;
            pa_func_r <= PA_FUNC_RST;
            pa_data_r <= PA_DATA_RST;
        end else if (wr_now) begin
            if (ap_addr_r == MODE_ADDR) begin
                mode_r <= hwdata[7:0];
            end else if (ap_addr_r == TXDATA_ADDR) begin
                txdata_r <= hwdata[15:0];
            end else if (ap_addr_r == PA_DIR_ADDR) begin
                pa_dir_r <= hwdata[15:0];
            end else if (ap_addr_r == PA_FUNC_ADDR) begin
                pa_func_r <= hwdata[15:0];
            end else if (ap_addr_r == PA_DATA_ADDR) begin
                pa_data_r <= hwdata[15:0];
            end
        end
    end

    // Mode decode: invert bit and divider, 2F gives invert and 32
    assign inv  = mode_r[MODE_INV_BIT];
    assign half = mode_r[MODE_DIV_LSB +: 4];
    assign tick = (div_cnt_r == 4'h0);
    assign last_bit = (bit_cnt_r == bit_total_r - 5'd1);
    assign finish   = (state_r == S_TRAIL) & tick & last_bit;

    // Shift engine: lead edge drives out, trail edge samples in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= S_IDLE;
            shift_r     <= 16'h0000;
            bit_cnt_r   <= 5'd0;
            bit_total_r <= BITS_ONE;
            div_cnt_r   <= 4'h0;
            sclk_r      <= 1'b0;
            mosi_r      <= 1'b0;
            rxdata_r    <= 16'h0000;
        end else begin
            case (state_r)
                S_IDLE: begin
                    sclk_r <= inv;
                    if (go) begin
                        shift_r     <= frame;
                        bit_total_r <= two ? BITS_TWO : BITS_ONE;
                        bit_cnt_r   <= 5'd0;
                        div_cnt_r   <= half;
                        rxdata_r    <= 16'h0000;
                        state_r     <= S_LEAD;
                    end
                end
                S_LEAD: begin
                    if (tick) begin
                        sclk_r    <= ~inv; // Falling edge when inverted
                        mosi_r    <= shift_r[15];
                        shift_r   <= {shift_r[14:0], 1'b0};
                        div_cnt_r <= half;
                        state_r   <= S_TRAIL;
                    end else begin
                        div_cnt_r <= div_cnt_r - 4'h1;
                    end
                end
                S_TRAIL: begin
                    if (tick) begin
                        sclk_r    <= inv; // Rising edge when inverted
                        rxdata_r  <= {rxdata_r[14:0], miso_s};
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        div_cnt_r <= half;
                        state_r   <= last_bit ? S_IDLE : S_LEAD;
                    end else begin
                        div_cnt_r <= div_cnt_r - 4'h1;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    assign link_out.sclk = sclk_r;
    assign link_out.mosi = mosi_r;

    // Sticky flags; a hardware set wins over a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r   <= 1'b0;
            refuse_r <= 1'b0;
            delta_r  <= 1'b0;
        end else begin
            done_r   <= finish | (done_r & ~(status_wr & hwdata[ST_DONE_BIT]));
            refuse_r <= (go_req & ~go) | (refuse_r & ~(status_wr & hwdata[ST_REFUSE_BIT]));
            delta_r  <= hs_change | (delta_r & ~(status_wr & hwdata[ST_DELTA_BIT]));
        end
    end

    // Termination mode tracks which configuration preset was sent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nt_mode_r <= 1'b0;
        end else if (go & (preset == PRE_NT_CFG)) begin
            nt_mode_r <= 1'b1;
        end else if (go & (preset == PRE_TE_CFG)) begin
            nt_mode_r <= 1'b0;
        end
    end

    // Two-flop synchronisers for all pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_meta_r <= 16'h0000;
            pa_sync_r <= 16'h0000;
            meta_r    <= 2'b01;
            sync_r    <= 2'b01;
        end else begin
            pa_meta_r <= port_a_in;
            pa_sync_r <= pa_meta_r;
            meta_r    <= {link_miso, xcvr_irq_n};
            sync_r    <= meta_r;
        end
    end

    assign miso_s = sync_r[1];
    assign irq_s  = ~sync_r[0];
    assign level_one_irq_input = irq_s;

    // Dedicated handshake inputs and change detection
    assign ded_cts   = pa_func_r[PA_CTS_PIN];
    assign ded_cd    = pa_func_r[PA_CD_PIN];
    assign hs_change = (ded_cts & (pa_sync_r[PA_CTS_PIN] != hs_last_r[0]))
                     | (ded_cd & (pa_sync_r[PA_CD_PIN] != hs_last_r[1]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_last_r <= 2'b00;
        end else begin
            hs_last_r <= {pa_sync_r[PA_CD_PIN], pa_sync_r[PA_CTS_PIN]};
        end
    end

    assign chan2_change_event   = hs_change;
    assign chan2_rx_line        = pa_func_r[PA_RXD_PIN] ? pa_sync_r[PA_RXD_PIN] : 1'b1;
    assign chan2_clear_to_send  = ded_cts ? pa_sync_r[PA_CTS_PIN] : 1'b1;
    assign chan2_carrier_detect = ded_cd ? pa_sync_r[PA_CD_PIN] : 1'b1;

    // Pin drive: dedicated outputs override, dedicated inputs never driven, else direction and data
    always_comb begin
        port_a.out = pa_data_r;
        port_a.oe  = pa_dir_r & ~pa_func_r;
        port_a.out[PA_TXD_PIN]  = pa_func_r[PA_TXD_PIN] ? chan2_tx_line : pa_data_r[PA_TXD_PIN];
        port_a.oe[PA_TXD_PIN]   = pa_func_r[PA_TXD_PIN] | pa_dir_r[PA_TXD_PIN];
        port_a.out[PA_TCLK_PIN] = pa_func_r[PA_TCLK_PIN] ? chan2_tx_clock : pa_data_r[PA_TCLK_PIN];
        port_a.oe[PA_TCLK_PIN]  = pa_func_r[PA_TCLK_PIN] | pa_dir_r[PA_TCLK_PIN];
    end

endmodule

// >>> xcvr_model.sv
/* Transceiver model on the serial control link.
   Assumes invert clock mode and an active high select. */
`timescale 1ns/100ps
module xcvr_model (
    // Link and discretes
    input  wire logic        clk,
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        sel,
    input  wire logic        rst_n,
    input  wire logic        irq_req,
    output logic             miso,
    output logic             irq_n,
    // Observation
    output logic      [15:0] cap,
    output logic      [4:0]  cnt,
    output logic      [7:0]  per
);
    logic [15:0] sr;
    logic [7:0]  t;
    initial {miso, t, per} = 17'h00000;
    // Reply loads on select
    always @(posedge sel) begin
        sr = 16'ha53c;
        cnt = 5'h00;
    end
    // Reply bits leave on falling edges, MSB first
    always @(negedge sclk) if (sel) begin
        miso = sr[15];
        sr = sr << 1;
    end
    // Released line shows no stale value
    always @(negedge sel) miso = ~miso;
    // Command bits taken on rising edges
    always @(posedge sclk) if (sel) begin
        cap = {cap[14:0], mosi};
        cnt = cnt + 5'h01;
        per = t;
        t = 8'h00;
    end
    always @(posedge clk) t = t + 8'h01;
    // Reset clears captured state
    always @(negedge rst_n) cap = 16'h0000;
    assign irq_n = rst_n ? ~irq_req : 1'b1;
endmodule

// >>> st_ctrl_chk.sv
/* Checker for the control master: bus timing, link edges, irq, pulses.
   Sees only the master's ports. */
`timescale 1ns/100ps
module st_ctrl_chk import st_ctrl_pkg::*; (
    // Bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins
    input wire link_out_t   link_out,
    input wire port_drive_t port_a,
    input wire logic        xcvr_irq_n,
    input wire logic        level_one_irq_input,
    input wire logic        chan2_change_event
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire sel_on  = port_a.oe[PA_SEL_PIN] && port_a.out[PA_SEL_PIN];
    wire rd_take = hsel && htrans[1] && hready && !hwrite;
    wire wr_take = hsel && htrans[1] && hready && hwrite;
    // Bus answers
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    write_zero_a: assert property (wr_take |=> hreadyout)
        else $error("write waited");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(!hreadyout))
        else $error("hrdata moved");
    // Link and discretes
    irq_sync_a: assert property (level_one_irq_input == !$past(xcvr_irq_n, 2))
        else $error("irq level wrong");
    mosi_edge_a: assert property ($changed(link_out.mosi) |-> $changed(link_out.sclk))
        else $error("mosi off edge");
    mosi_high_a: assert property (link_out.sclk && $past(link_out.sclk)
        |-> $stable(link_out.mosi)) else $error("mosi moved high");
    sel_frame_a: assert property ($fell(link_out.sclk) |-> sel_on)
        else $error("clock without select");
    event_pulse_a: assert property (chan2_change_event |=> !chan2_change_event)
        else $error("event too long");
    frame_c: cover property ($fell(link_out.sclk));
    event_c: cover property (chan2_change_event);
    read_c: cover property (rd_take ##2 hreadyout);
endmodule
bind st_ctrl_master st_ctrl_chk chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .link_out, .port_a, .xcvr_irq_n, .level_one_irq_input,
    .chan2_change_event);

// >>> st_ctrl_master_test.sv
/* Bench for the control master: bus tasks and one task per test.
   Assumes the bound checker and the transceiver model. */
`timescale 1ns/100ps
module st_ctrl_master_test;
    import st_ctrl_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_req = 0;
    logic        txl = 0, txc = 0, hready, hreadyout, hresp, miso, irq_n;
    logic        l1, rxl, cts, cd, ev, rdy_q, sel;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q, q;
    logic [15:0] pin_in = 16'h0, pa_in, cap;
    logic [4:0]  cnt;
    logic [7:0]  per;
    link_out_t   lo;
    port_drive_t pa;
    int          fail_count = 0, n_compared = 0;
    assign hready = hreadyout;
    assign sel = pa.oe[PA_SEL_PIN] & pa.out[PA_SEL_PIN];
    assign pa_in = (pa.oe & pa.out) | (~pa.oe & pin_in);
    always #2.5 hclk = ~hclk;
    // Bus answer as seen at each edge
    always @(posedge hclk) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
    end
    st_ctrl_master dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .link_out(lo),
        .link_miso(miso), .port_a(pa), .port_a_in(pa_in), .xcvr_irq_n(irq_n),
        .level_one_irq_input(l1), .chan2_rx_line(rxl), .chan2_tx_line(txl),
        .chan2_tx_clock(txc), .chan2_clear_to_send(cts), .chan2_carrier_detect(cd),
        .chan2_change_event(ev));
    xcvr_model far (.clk(hclk), .sclk(lo.sclk), .mosi(lo.mosi), .sel(sel),
        .rst_n(pa_in[PA_XRST_PIN]), .irq_req(irq_req), .miso(miso), .irq_n(irq_n),
        .cap(cap), .cnt(cnt), .per(per));
    task check(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task edge1();
        @(posedge hclk) #1;
    endtask
    // One word transfer, waits for the slave
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do edge1(); while (rdy_q !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do edge1(); while (rdy_q !== 1'b1);
        q = rd_q;
    endtask
    task t_reset();
        bus(1'b0, MODE_ADDR, 32'h0);
        check(q, {24'h0, MODE_RST});
        bus(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        check({16'h0, pa.oe}, {16'h0, PA_DIR_RST});
        $display("reset test done");
    endtask
    task t_port();
        bus(1'b1, PA_DIR_ADDR, {16'h0, PA_DIR_TYPICAL});
        bus(1'b1, PA_FUNC_ADDR, {16'h0, PA_FUNC_POLLED});
        bus(1'b1, PA_DATA_ADDR, 32'h0);
        check({16'h0, pa.oe}, 32'h01ae);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check({31'h0, q[ST_XRST_BIT]}, 32'h1);
        txl <= 1'b1;
        pin_in[PA_CTS_PIN] <= 1'b1;
        bus(1'b1, PA_DATA_ADDR, 32'h100);
        bus(1'b0, PA_DATA_ADDR, 32'h0);
        check({31'h0, q[PA_CTS_PIN]}, 32'h1);
        check({31'h0, pa.out[PA_TXD_PIN]}, 32'h1);
        bus(1'b1, PA_FUNC_ADDR, {16'h0, PA_FUNC_MODEM});
        bus(1'b1, STATUS_ADDR, 32'h8);
        pin_in[PA_CD_PIN] <= 1'b1;
        repeat (4) edge1();
        check({29'h0, rxl, cts, cd}, 32'h3);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check({31'h0, q[ST_DELTA_BIT]}, 32'h1);
        $display("port test done");
    endtask
    task t_irq();
        irq_req <= 1'b1;
        bus(1'b0, STATUS_ADDR, 32'h0);
        check({30'h0, l1, q[ST_IRQ_BIT]}, 32'h3);
        irq_req <= 1'b0;
        repeat (3) edge1();
        check({31'h0, l1}, 32'h0);
        $display("irq test done");
    endtask
    task automatic t_frame(input logic [7:0] c, input logic [15:0] tx, e, input logic [4:0] n);
        int k;
        bus(1'b1, PA_DATA_ADDR, 32'h180);
        bus(1'b1, TXDATA_ADDR, {16'h0, tx});
        bus(1'b1, CTRL_ADDR, {24'h0, c});
        bus(1'b0, STATUS_ADDR, 32'h0);
        check({31'h0, q[ST_BUSY_BIT]}, 32'h1);
        k = 0;
        do begin
            bus(1'b0, STATUS_ADDR, 32'h0);
            k++;
        end while (q[ST_DONE_BIT] !== 1'b1 && k < 400);
        check({11'h0, cnt, n == BITS_TWO ? cap : {8'h0, cap[7:0]}}, {11'h0, n, e});
        check({23'h0, lo.sclk, per}, 32'h120);
        bus(1'b0, RXDATA_ADDR, 32'h0);
        check(n == BITS_TWO ? q : {24'h0, q[7:0]}, n == BITS_TWO ? 32'ha53c : 32'ha5);
        bus(1'b1, PA_DATA_ADDR, 32'h100);
        bus(1'b1, STATUS_ADDR, 32'h2);
    endtask
    task t_refuse(input logic [7:0] d, c);
        bus(1'b1, PA_DATA_ADDR, {24'h0, d});
        bus(1'b1, CTRL_ADDR, {24'h0, c});
        bus(1'b0, STATUS_ADDR, 32'h0);
        check({29'h0, q[2:0]}, 32'h4);
        bus(1'b1, STATUS_ADDR, 32'h4);
    endtask
    task t_link();
        bus(1'b1, MODE_ADDR, {24'h0, MODE_TYPICAL});
        t_frame(8'h03, 16'h1234, 16'h1234, BITS_TWO);
        t_frame(8'h01, 16'hc300, 16'h00c3, BITS_ONE);
        t_frame({1'b0, PRE_TE_CFG, 4'h0}, 16'h0,
                {BYTE_WR_HDR[7:3], CFG_BYTE_REG, CFG_TE_VALUE}, BITS_TWO);
        t_frame({1'b0, PRE_TE_BCH, 4'h0}, 16'h0,
                {8'h0, BCH_NIB_REG, BCH_BOTH_VALUE}, BITS_ONE);
        t_frame({1'b0, PRE_LOOP_ON, 4'h0}, 16'h0,
                {8'h0, LOOP_NIB_REG, LOOP_ACT_VALUE}, BITS_ONE);
        t_refuse(8'h00, 8'h01);
        t_refuse(8'h80, {1'b0, PRE_LOOP_OFF, 4'h0});
        bus(1'b1, PA_DATA_ADDR, 32'h100);
        t_frame({1'b0, PRE_NT_CFG, 4'h0}, 16'h0,
                {BYTE_WR_HDR[7:3], CFG_BYTE_REG, CFG_NT_VALUE}, BITS_TWO);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check({31'h0, q[ST_NT_BIT]}, 32'h1);
        t_frame({1'b0, PRE_LOOP_OFF, 4'h0}, 16'h0,
                {8'h0, LOOP_NIB_REG, LOOP_DEACT_VAL}, BITS_ONE);
        t_frame({1'b0, PRE_MASK, 4'h0}, 16'h0009,
                {8'h0, MASK_NIB_REG, 4'h9}, BITS_ONE);
        $display("link test done");
    endtask
    task close_out();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_port();
        t_irq();
        t_link();
        close_out();
    end
endmodule
